// >>> rtl/dram_timing_pkg.sv
// Constants and cycle-conversion helpers for the memory sequencing controller.
package dram_timing_pkg;

    // Termination hold counts for eight-beat writes, one- and two-clock preamble.
    localparam logic [15:0] TERM_HOLD_WRITE_BURST8_1CK = 16'h0006;
    localparam logic [15:0] TERM_HOLD_WRITE_BURST8_2CK = 16'h0007;
    // Termination hold counts without a write or with chop-four writes.
    localparam logic [15:0] TERM_HOLD_CHOP_OR_IDLE_1CK = 16'h0004;
    localparam logic [15:0] TERM_HOLD_CHOP_OR_IDLE_2CK = 16'h0005;
    // Leveling waits counted from the leveling mode write.
    localparam logic [15:0] LEVELING_STROBE_ENABLE_WAIT = 16'h0019;
    localparam logic [15:0] LEVELING_FIRST_STROBE_WAIT = 16'h0028;
    // Extra clocks added to the mode update delay before the sync pulse.
    localparam logic [15:0] GEAR_SYNC_EXTRA_CK = 16'h0004;
    // Sync pulse stability before and after its sampling edge.
    localparam logic [15:0] GEAR_PULSE_SETUP = 16'h0002;
    localparam logic [15:0] GEAR_PULSE_HOLD = 16'h0002;
    // Least select-to-command latency in clocks and in picoseconds.
    localparam logic [7:0] SELECT_CMD_MIN_CK = 8'h03;
    localparam logic [31:0] SELECT_CMD_MIN_PS = 32'h0000_0EA4;
    // Slowest rate with its own timing set, and the clock period used below it.
    localparam logic [15:0] SLOW_RATE_FLOOR = 16'h0640;
    localparam logic [15:0] SLOW_RATE_TCK_PS = 16'h04E2;
    // Least data rate at which gear-down may be enabled.
    localparam logic [15:0] GEAR_MIN_RATE = 16'h0A6A;
    // Inverse adjustment factor numerator and its scale.
    localparam logic [31:0] ADJUST_NUM = 32'h0000_03CE;
    localparam logic [31:0] ADJUST_SCALE = 32'h0000_03E8;

    // Request kinds taken at the user port.
    localparam logic [2:0] KIND_WRITE_BURST8 = 3'h0;
    localparam logic [2:0] KIND_WRITE_CHOP = 3'h1;
    localparam logic [2:0] KIND_TERM_ONLY = 3'h2;
    localparam logic [2:0] KIND_LEVELING = 3'h3;
    localparam logic [2:0] KIND_GEAR_DOWN = 3'h4;
    localparam logic [2:0] KIND_REFRESH = 3'h5;

    // Command codes driven at the memory side with the command strobe.
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_MODE_LEVELING = 3'h2;
    localparam logic [2:0] CMD_MODE_GEAR = 3'h3;
    localparam logic [2:0] CMD_REFRESH = 3'h4;
    localparam logic [2:0] CMD_FIRST_VALID = 3'h5;

    // Clock count of an SPD-kind parameter: truncate(ps / tck + 974/1000).
    function automatic logic [15:0] spd_cycles(input logic [19:0] ps, input logic [15:0] tck);
        logic [31:0] num;
        logic [31:0] den;
        num = 32'(ps) * ADJUST_SCALE + 32'(tck) * ADJUST_NUM;
        den = 32'(tck) * ADJUST_SCALE;
        return 16'(num / den);
    endfunction : spd_cycles

    // Clock count of a plain time parameter: ceiling(ps / tck).
    function automatic logic [15:0] ceil_cycles(input logic [19:0] ps, input logic [15:0] tck);
        logic [31:0] num;
        num = 32'(ps) + 32'(tck) - 32'h1;
        return 16'(num / 32'(tck));
    endfunction : ceil_cycles

endpackage : dram_timing_pkg

// >>> rtl/level_sync.sv
// Two-flip-flop synchroniser for one level signal.
`timescale 1ns/1ns
module level_sync
    import dram_timing_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);

    // Both stages of the synchroniser.
    typedef struct packed {
        logic stage1;
        logic stage2;
    } sync_state_type;

    sync_state_type cur_ff;
    sync_state_type nxt_cur;

    // The first stage only feeds the second stage.
    always_comb begin
        nxt_cur.stage1 = din;
        nxt_cur.stage2 = cur_ff.stage1;
    end

    // Registers both stages, clearing on reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign dout = cur_ff.stage2;

endmodule : level_sync

// >>> rtl/dram_seq_host.sv
// Memory-side sequencer that keeps termination, leveling, gear-down and refresh timing.
`timescale 1ns/1ns
module dram_seq_host
    import dram_timing_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic REQ_VALID,
    input wire logic [2:0] REQ_KIND,
    output logic REQ_READY,
    output logic REQ_DONE,
    output logic REQ_REFUSED,
    input wire logic TWO_CLK_PREAMBLE,
    input wire logic PARITY_ON,
    input wire logic DLL_OFF,
    input wire logic [15:0] DATA_RATE,
    input wire logic [15:0] TCK_PS,
    input wire logic [15:0] MOD_CYCLES,
    input wire logic [15:0] PARITY_LATENCY,
    input wire logic [19:0] RESET_EXIT_PS,
    input wire logic [19:0] SELF_REFRESH_EXIT_PS,
    input wire logic [19:0] REFRESH_CYCLE_PS,
    output logic [7:0] SELECT_CMD_LATENCY,
    input wire logic LINK_CLK,
    output logic MEM_CKE,
    output logic TERM_CTRL,
    output logic CMD_STROBE,
    output logic [2:0] CMD_CODE,
    output logic GEAR_SYNC,
    output logic STROBE_OUT,
    output logic STROBE_OE_N
);

    ////////////////////////////////////////////////////////////////////////////
    // User-clock side: takes requests and turns times into clock counts.

    // State of the user-clock side, including the job words held for the link.
    typedef struct packed {
        logic busy;
        logic req_tgl;
        logic ack_seen;
        logic done;
        logic refused;
        logic [2:0] kind;
        logic [15:0] cnt_a;
        logic [15:0] cnt_b;
        logic [7:0] cal_min;
    } host_state_type;

    host_state_type host_ff;
    host_state_type nxt_host;
    logic ack_sync; // Acknowledge toggle from the link side, synchronised.
    logic [15:0] eff_tck; // Clock period used for conversions.
    logic [15:0] xpr_ck; // Reset-exit wait in clocks.
    logic [15:0] xs_ck; // Self-refresh-exit wait in clocks.
    logic [15:0] rfc_ck; // Refresh cycle wait in clocks.
    logic [15:0] cal_ck; // Time part of the select latency in clocks.

    // Converts the time figures into clock counts for the active rate.
    always_comb begin
        eff_tck = (DATA_RATE < SLOW_RATE_FLOOR) ? SLOW_RATE_TCK_PS : TCK_PS;
        xpr_ck = ceil_cycles(RESET_EXIT_PS, eff_tck);
        xs_ck = ceil_cycles(SELF_REFRESH_EXIT_PS, eff_tck);
        cal_ck = ceil_cycles(20'(SELECT_CMD_MIN_PS), eff_tck);
        rfc_ck = spd_cycles(REFRESH_CYCLE_PS, eff_tck);
    end

    // Accepts one request at a time and waits for the link to finish it.
    always_comb begin
        nxt_host = host_ff;
        nxt_host.done = 1'b0;
        nxt_host.refused = 1'b0;
        nxt_host.ack_seen = ack_sync;
        if (cal_ck > 16'(SELECT_CMD_MIN_CK)) begin
            nxt_host.cal_min = cal_ck[7:0];
        end else begin
            nxt_host.cal_min = SELECT_CMD_MIN_CK;
        end
        if (host_ff.busy) begin
            // A changed acknowledge toggle marks the end of the job.
            if (ack_sync != host_ff.ack_seen) begin
                nxt_host.busy = 1'b0;
                nxt_host.done = 1'b1;
            end
        end else if (REQ_VALID) begin
            if (REQ_KIND == KIND_GEAR_DOWN && DATA_RATE < GEAR_MIN_RATE) begin
                nxt_host.refused = 1'b1;
            end else if (REQ_KIND > KIND_REFRESH) begin
                nxt_host.refused = 1'b1;
            end else begin
                nxt_host.busy = 1'b1;
                nxt_host.req_tgl = ~host_ff.req_tgl;
                nxt_host.kind = REQ_KIND;
                nxt_host.cnt_b = MOD_CYCLES;
                unique case (REQ_KIND)
                    KIND_WRITE_BURST8: begin
                        nxt_host.cnt_a = TWO_CLK_PREAMBLE ? TERM_HOLD_WRITE_BURST8_2CK
                                                          : TERM_HOLD_WRITE_BURST8_1CK;
                    end
                    KIND_WRITE_CHOP, KIND_TERM_ONLY: begin
                        nxt_host.cnt_a = TWO_CLK_PREAMBLE ? TERM_HOLD_CHOP_OR_IDLE_2CK
                                                          : TERM_HOLD_CHOP_OR_IDLE_1CK;
                    end
                    KIND_GEAR_DOWN: begin
                        nxt_host.cnt_a = (xpr_ck > xs_ck) ? xpr_ck : xs_ck;
                    end
                    KIND_REFRESH: begin
                        nxt_host.cnt_a = (PARITY_ON && DLL_OFF) ? 16'(rfc_ck + PARITY_LATENCY)
                                                                : rfc_ck;
                    end
                    default: begin
                        nxt_host.cnt_a = 16'h0000;
                    end
                endcase
            end
        end
    end

    // Registers the user-side state.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            host_ff <= '0;
        end else begin
            host_ff <= nxt_host;
        end
    end

    assign REQ_READY = ~host_ff.busy;
    assign REQ_DONE = host_ff.done;
    assign REQ_REFUSED = host_ff.refused;
    assign SELECT_CMD_LATENCY = host_ff.cal_min;

    ////////////////////////////////////////////////////////////////////////////
    // Link-clock side: drives the memory pins cycle by cycle.

    // Sequencer states of the link side.
    typedef enum logic [2:0] {
        L_IDLE = 3'b000,
        L_WRITE = 3'b001,
        L_LEVEL = 3'b010,
        L_GEAR_EXIT = 3'b011,
        L_GEAR_WAIT = 3'b100,
        L_GEAR_PULSE = 3'b101,
        L_GEAR_CMD = 3'b110,
        L_REFRESH = 3'b111
    } link_phase_type;

    // State of the link side, all pin drivers included.
    typedef struct packed {
        link_phase_type phase;
        logic [15:0] cnt;
        logic req_seen;
        logic ack_tgl;
        logic cke;
        logic termination_control_input;
        logic cmd_stb;
        logic [2:0] cmd_code;
        logic sync;
        logic strobe;
        logic strobe_oe_n;
    } link_state_type;

    link_state_type link_ff;
    link_state_type nxt_link;
    logic link_rst; // Reset brought into the link clock.
    logic req_sync; // Request toggle from the user side, synchronised.
    logic [15:0] cnt_inc; // Cycle count including the present cycle.

    // Brings the reset level into the link clock.
    level_sync rst_sync_u (
        .clk(LINK_CLK),
        .rst(1'b0),
        .din(SYS_RST),
        .dout(link_rst)
    );

    // Brings the request toggle into the link clock.
    level_sync req_sync_u (
        .clk(LINK_CLK),
        .rst(link_rst),
        .din(host_ff.req_tgl),
        .dout(req_sync)
    );

    // Brings the link acknowledge toggle back into the user clock.
    level_sync ack_sync_u (
        .clk(CLOCK),
        .rst(SYS_RST),
        .din(link_ff.ack_tgl),
        .dout(ack_sync)
    );

    // Steps the pin sequence; job words are stable while the user side is busy.
    always_comb begin
        nxt_link = link_ff;
        nxt_link.cmd_stb = 1'b0;
        nxt_link.req_seen = req_sync;
        cnt_inc = 16'(link_ff.cnt + 16'h0001);
        nxt_link.cnt = cnt_inc;
        unique case (link_ff.phase)
            L_IDLE: begin
                nxt_link.cnt = 16'h0000;
                if (req_sync != link_ff.req_seen) begin
                    unique case (host_ff.kind)
                        KIND_WRITE_BURST8, KIND_WRITE_CHOP: begin
                            nxt_link.termination_control_input = 1'b1;
                            nxt_link.cmd_stb = 1'b1;
                            nxt_link.cmd_code = CMD_WRITE;
                            nxt_link.phase = L_WRITE;
                        end
                        KIND_TERM_ONLY: begin
                            nxt_link.termination_control_input = 1'b1;
                            nxt_link.phase = L_WRITE;
                        end
                        KIND_LEVELING: begin
                            nxt_link.cmd_stb = 1'b1;
                            nxt_link.cmd_code = CMD_MODE_LEVELING;
                            nxt_link.phase = L_LEVEL;
                        end
                        KIND_GEAR_DOWN: begin
                            // Exit wait counts from clock enable going high.
                            nxt_link.cke = 1'b1;
                            nxt_link.phase = L_GEAR_EXIT;
                        end
                        default: begin
                            nxt_link.cmd_stb = 1'b1;
                            nxt_link.cmd_code = CMD_REFRESH;
                            nxt_link.phase = L_REFRESH;
                        end
                    endcase
                end
            end
            L_WRITE: begin
                if (cnt_inc >= host_ff.cnt_a) begin
                    nxt_link.termination_control_input = 1'b0;
                    nxt_link.ack_tgl = ~link_ff.ack_tgl;
                    nxt_link.phase = L_IDLE;
                end
            end
            L_LEVEL: begin
                if (cnt_inc == LEVELING_STROBE_ENABLE_WAIT) begin
                    nxt_link.strobe_oe_n = 1'b0;
                end
                if (cnt_inc == LEVELING_FIRST_STROBE_WAIT) begin
                    nxt_link.strobe = 1'b1;
                end
                if (cnt_inc > LEVELING_FIRST_STROBE_WAIT) begin
                    nxt_link.strobe = 1'b0;
                    nxt_link.strobe_oe_n = 1'b1;
                    nxt_link.ack_tgl = ~link_ff.ack_tgl;
                    nxt_link.phase = L_IDLE;
                end
            end
            L_GEAR_EXIT: begin
                if (cnt_inc >= host_ff.cnt_a) begin
                    nxt_link.cmd_stb = 1'b1;
                    nxt_link.cmd_code = CMD_MODE_GEAR;
                    nxt_link.cnt = 16'h0000;
                    nxt_link.phase = L_GEAR_WAIT;
                end
            end
            L_GEAR_WAIT: begin
                if (cnt_inc >= 16'(host_ff.cnt_b + GEAR_SYNC_EXTRA_CK - GEAR_PULSE_SETUP)) begin
                    nxt_link.sync = 1'b1;
                    nxt_link.cnt = 16'h0000;
                    nxt_link.phase = L_GEAR_PULSE;
                end
            end
            L_GEAR_PULSE: begin
                if (cnt_inc > 16'(GEAR_PULSE_SETUP + GEAR_PULSE_HOLD)) begin
                    nxt_link.sync = 1'b0;
                    nxt_link.cnt = 16'h0000;
                    nxt_link.phase = L_GEAR_CMD;
                end
            end
            L_GEAR_CMD: begin
                if (cnt_inc >= 16'(host_ff.cnt_b - GEAR_PULSE_HOLD)) begin
                    nxt_link.cmd_stb = 1'b1;
                    nxt_link.cmd_code = CMD_FIRST_VALID;
                    nxt_link.ack_tgl = ~link_ff.ack_tgl;
                    nxt_link.phase = L_IDLE;
                end
            end
            L_REFRESH: begin
                if (cnt_inc >= host_ff.cnt_a) begin
                    nxt_link.ack_tgl = ~link_ff.ack_tgl;
                    nxt_link.phase = L_IDLE;
                end
            end
        endcase
    end

    // Registers the link-side state; strobe drivers are released on reset.
    always_ff @(posedge LINK_CLK) begin
        if (link_rst) begin
            link_ff <= '0;
            link_ff.strobe_oe_n <= 1'b1;
        end else begin
            link_ff <= nxt_link;
        end
    end

    assign MEM_CKE = link_ff.cke;
    assign TERM_CTRL = link_ff.termination_control_input;
    assign CMD_STROBE = link_ff.cmd_stb;
    assign CMD_CODE = link_ff.cmd_code;
    assign GEAR_SYNC = link_ff.sync;
    assign STROBE_OUT = link_ff.strobe;
    assign STROBE_OE_N = link_ff.strobe_oe_n;

endmodule : dram_seq_host

// >>> tb/dram_seq_checker.sv
// Concurrent checks on the ports of the memory sequencing controller.
`timescale 1ns/1ns
module dram_seq_checker
    import dram_timing_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic REQ_VALID,
    input wire logic [2:0] REQ_KIND,
    input wire logic REQ_REFUSED,
    input wire logic TWO_CLK_PREAMBLE,
    input wire logic [15:0] DATA_RATE,
    input wire logic [15:0] MOD_CYCLES,
    input wire logic [7:0] SELECT_CMD_LATENCY,
    input wire logic LINK_CLK,
    input wire logic MEM_CKE,
    input wire logic TERM_CTRL,
    input wire logic CMD_STROBE,
    input wire logic [2:0] CMD_CODE,
    input wire logic GEAR_SYNC,
    input wire logic STROBE_OUT,
    input wire logic STROBE_OE_N
);
    // Link cycles since the last gear write or sync rise.
    logic [15:0] cnt_ff;
    // Sync level one link cycle ago.
    logic sync_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // The counter restarts at each gear-down milestone and saturates.
    always_ff @(posedge LINK_CLK) begin
        sync_ff <= GEAR_SYNC;
        if (SYS_RST || (CMD_STROBE && CMD_CODE == CMD_MODE_GEAR) || (GEAR_SYNC && !sync_ff)) begin
            cnt_ff <= 16'h0000;
        end else if (cnt_ff != 16'hFFFF) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // shortest termination hold.
    a_term_hold_min: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        $rose(TERM_CTRL) |-> TERM_CTRL[*4]) else $error("Termination dropped early.");
    a_term_hold_two: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        $rose(TERM_CTRL) && TWO_CLK_PREAMBLE |-> TERM_CTRL[*5])
        else $error("Termination short in two-clock mode.");
    a_level_oe_wait: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        CMD_STROBE && CMD_CODE == CMD_MODE_LEVELING |-> ##24 STROBE_OE_N ##1 !STROBE_OE_N)
        else $error("Strobe drivers enabled at the wrong time.");
    a_level_edge_wait: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        CMD_STROBE && CMD_CODE == CMD_MODE_LEVELING |-> ##39 !STROBE_OUT ##1 STROBE_OUT)
        else $error("First strobe edge at the wrong time.");
    a_strobe_driven: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        STROBE_OUT |-> !STROBE_OE_N) else $error("Strobe high while not driven.");
    a_gear_cke_high: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        CMD_STROBE && CMD_CODE == CMD_MODE_GEAR |-> MEM_CKE && $past(MEM_CKE))
        else $error("Gear write without clock enable.");
    a_sync_after_mod: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        $rose(GEAR_SYNC) |-> cnt_ff == MOD_CYCLES + 16'h0001)
        else $error("Sync pulse at the wrong time.");
    a_sync_width: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        $rose(GEAR_SYNC) |-> GEAR_SYNC[*5] ##1 !GEAR_SYNC) else $error("Sync width wrong.");
    a_first_cmd_wait: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        CMD_STROBE && CMD_CODE == CMD_FIRST_VALID |-> cnt_ff == MOD_CYCLES + 16'h0002)
        else $error("First command at the wrong time.");
    a_select_min: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> SELECT_CMD_LATENCY >= SELECT_CMD_MIN_CK)
        else $error("Select latency below floor.");
    a_gear_refused: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        REQ_VALID && REQ_KIND == KIND_GEAR_DOWN && DATA_RATE < GEAR_MIN_RATE |=> REQ_REFUSED)
        else $error("No refusal.");
    // Main scenarios reached.
    c_level: cover property (@(posedge LINK_CLK) CMD_STROBE && CMD_CODE == CMD_MODE_LEVELING);
    c_sync: cover property (@(posedge LINK_CLK) $rose(GEAR_SYNC));
    c_refuse: cover property (@(posedge CLOCK) REQ_REFUSED);
endmodule : dram_seq_checker

bind dram_seq_host dram_seq_checker chk_u (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID), .REQ_KIND(REQ_KIND),
    .REQ_REFUSED(REQ_REFUSED), .TWO_CLK_PREAMBLE(TWO_CLK_PREAMBLE), .DATA_RATE(DATA_RATE),
    .MOD_CYCLES(MOD_CYCLES), .SELECT_CMD_LATENCY(SELECT_CMD_LATENCY), .LINK_CLK(LINK_CLK),
    .MEM_CKE(MEM_CKE), .TERM_CTRL(TERM_CTRL), .CMD_STROBE(CMD_STROBE), .CMD_CODE(CMD_CODE),
    .GEAR_SYNC(GEAR_SYNC), .STROBE_OUT(STROBE_OUT), .STROBE_OE_N(STROBE_OE_N)
);

// >>> tb/dram_device_model.sv
// Behavioural memory device that watches the command side and logs its timing.
`timescale 1ns/1ns
module dram_device_model
    import dram_timing_pkg::*;
(
    input wire logic link_clk,
    input wire logic rst,
    input wire logic mem_cke,
    input wire logic term_ctrl,
    input wire logic cmd_strobe,
    input wire logic [2:0] cmd_code,
    output logic [15:0] term_len,
    output logic [15:0] gear_wait,
    output logic [7:0] writes
);
    // All state of the device model.
    typedef struct packed {
        logic [15:0] term_run;
        logic [15:0] term_len;
        logic [15:0] cke_run;
        logic [15:0] gear_wait;
        logic [7:0] writes;
    } model_state_type;
    model_state_type state_ff;
    model_state_type nxt_state;
    ////////////////////////////////////////////////////////////////////////////////
    // Next state from the pins seen at each link edge.
    always_comb begin
        nxt_state = state_ff;
        // termination follows its control level, measured in whole clocks.
        nxt_state.term_run = term_ctrl ? state_ff.term_run + 16'h0001 : 16'h0000;
        if (!term_ctrl && state_ff.term_run != 16'h0000) begin
            nxt_state.term_len = state_ff.term_run;
        end
        nxt_state.cke_run = mem_cke ? state_ff.cke_run + 16'h0001 : 16'h0000;
        // gear write logged against clock-enable age.
        if (cmd_strobe && cmd_code == CMD_MODE_GEAR) begin
            nxt_state.gear_wait = state_ff.cke_run;
        end
        // each write starts one internal transaction.
        if (cmd_strobe && cmd_code == CMD_WRITE) begin
            nxt_state.writes = state_ff.writes + 8'h01;
        end
    end
    // State register, cleared by reset.
    always_ff @(posedge link_clk) begin
        state_ff <= rst ? '0 : nxt_state;
    end
    assign term_len = state_ff.term_len;
    assign gear_wait = state_ff.gear_wait;
    assign writes = state_ff.writes;
endmodule : dram_device_model

// >>> tb/testbench.sv
// Self-checking bench for the memory sequencing controller.
`timescale 1ns/1ns
module testbench
    import dram_timing_pkg::*;
;
    // One table case: inputs and the outputs they give.
    typedef struct packed {
        logic [2:0] kind;
        logic pre;
        logic [15:0] rate;
        logic [15:0] tck;
        logic [15:0] term;
        logic [7:0] sel;
    } row_type;
    row_type rows [6];
    logic clock, link_clk, sys_rst, req_valid, two_pre, parity_on, dll_off;
    logic [2:0] req_kind;
    logic [15:0] data_rate, tck_ps, mod_cycles, par_lat;
    logic [19:0] xpr_ps, xs_ps, rfc_ps;
    logic req_ready, req_done, req_refused, mem_cke, term_ctrl, cmd_strobe;
    logic gear_sync, strobe_out, strobe_oe_n, done, refused;
    logic [2:0] cmd_code;
    logic [7:0] sel_lat, writes, w0;
    logic [15:0] term_len, gear_wait;
    int fails, checks_done, cycles, i, rfc_n;
    time took, took2;
    ////////////////////////////////////////////////////////////////////////////////
    dram_seq_host dut_u (.CLOCK(clock), .SYS_RST(sys_rst), .REQ_VALID(req_valid),
        .REQ_KIND(req_kind), .REQ_READY(req_ready), .REQ_DONE(req_done),
        .REQ_REFUSED(req_refused), .TWO_CLK_PREAMBLE(two_pre), .PARITY_ON(parity_on),
        .DLL_OFF(dll_off), .DATA_RATE(data_rate), .TCK_PS(tck_ps), .MOD_CYCLES(mod_cycles),
        .PARITY_LATENCY(par_lat), .RESET_EXIT_PS(xpr_ps), .SELF_REFRESH_EXIT_PS(xs_ps),
        .REFRESH_CYCLE_PS(rfc_ps), .SELECT_CMD_LATENCY(sel_lat), .LINK_CLK(link_clk),
        .MEM_CKE(mem_cke), .TERM_CTRL(term_ctrl), .CMD_STROBE(cmd_strobe), .CMD_CODE(cmd_code),
        .GEAR_SYNC(gear_sync), .STROBE_OUT(strobe_out), .STROBE_OE_N(strobe_oe_n));
    dram_device_model mem_u (.link_clk(link_clk), .rst(sys_rst), .mem_cke(mem_cke),
        .term_ctrl(term_ctrl), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
        .term_len(term_len), .gear_wait(gear_wait), .writes(writes));
    ////////////////////////////////////////////////////////////////////////////////
    // User clock at 100 MHz.
    always #5 clock = ~clock;
    // Link clock at 160 ns, offset so its phase is unrelated.
    initial begin
        #33;
        forever #80 link_clk = ~link_clk;
    end
    // Hang guard: a stuck run counts as a mismatch.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            stop_test();
        end
    end
    // Compares one value against its expectation.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    // Holds reset over twenty link cycles and checks the idle outputs.
    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (20) @(posedge link_clk);
        @(posedge clock);
        #1;
        check({req_ready, req_done, req_refused, mem_cke, term_ctrl, strobe_oe_n}, 6'h21);
        sys_rst = 1'b0;
        repeat (4) @(posedge link_clk);
        @(posedge clock);
        #1;
    endtask : do_reset
    // Issues one request while idle and waits for its answer.
    task automatic run_req(input logic [2:0] kind);
        time t0;
        @(posedge clock);
        #1;
        req_valid = 1'b1;
        req_kind = kind;
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        t0 = $time;
        for (int n = 0; n < 20000; n++) begin
            done = (req_done === 1'b1);
            refused = (req_refused === 1'b1);
            if (done || refused) break;
            @(posedge clock);
            #1;
        end
        took = $time - t0;
        repeat (2) @(posedge link_clk);
        @(posedge clock);
        #1;
    endtask : run_req
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d.", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: table, then the awkward cases.
    initial begin
        {clock, link_clk, sys_rst, req_valid, two_pre, parity_on, dll_off} = 7'h04;
        req_kind = 3'h0;
        {data_rate, tck_ps, mod_cycles, par_lat} = {16'h0C80, 16'h0271, 16'h0006, 16'h0028};
        {xpr_ps, xs_ps, rfc_ps} = {20'h04E20, 20'h07530, 20'h04E3E};
        rows[0] = '{KIND_WRITE_BURST8, 1'b0, 16'h0C80, 16'h0271, TERM_HOLD_WRITE_BURST8_1CK, 8'h06};
        rows[1] = '{KIND_WRITE_BURST8, 1'b1, 16'h0A6A, 16'h02EE, TERM_HOLD_WRITE_BURST8_2CK, 8'h05};
        rows[2] = '{KIND_WRITE_CHOP, 1'b0, 16'h0578, 16'h0271, TERM_HOLD_CHOP_OR_IDLE_1CK, 8'h03};
        rows[3] = '{KIND_WRITE_CHOP, 1'b1, 16'h0C80, 16'h07D0, TERM_HOLD_CHOP_OR_IDLE_2CK, 8'h03};
        rows[4] = '{KIND_TERM_ONLY, 1'b0, 16'h0960, 16'h0341, TERM_HOLD_CHOP_OR_IDLE_1CK, 8'h05};
        rows[5] = '{KIND_TERM_ONLY, 1'b1, 16'h0C80, 16'h0271, TERM_HOLD_CHOP_OR_IDLE_2CK, 8'h06};
        do_reset();
        for (i = 0; i < 6; i++) begin
            two_pre = rows[i].pre;
            data_rate = rows[i].rate;
            tck_ps = rows[i].tck;
            w0 = writes;
            run_req(rows[i].kind);
            check(done, 1'b1);
            check(term_len, rows[i].term);
            check(writes - w0, rows[i].kind == KIND_TERM_ONLY ? 8'h00 : 8'h01);
            check(sel_lat, rows[i].sel);
        end
        $display("Test table done.");
        run_req(KIND_LEVELING);
        check(done, 1'b1);
        data_rate = 16'h0960;
        run_req(KIND_GEAR_DOWN);
        check({refused, mem_cke}, 2'h2);
        run_req(3'h7);
        check(refused, 1'b1);
        {data_rate, tck_ps} = {16'h0A6A, 16'h02EE};
        run_req(KIND_GEAR_DOWN);
        check(gear_wait >= (30000 + 750 - 1) / 750, 1'b1);
        check({done, mem_cke}, 2'h3);
        $display("Test leveling and gear done.");
        {data_rate, tck_ps, parity_on, dll_off} = {16'h0578, 16'h0271, 2'h3};
        rfc_n = (20030 * 1000 + 974 * SLOW_RATE_TCK_PS) / (SLOW_RATE_TCK_PS * 1000);
        run_req(KIND_REFRESH);
        took2 = took;
        dll_off = 1'b0;
        run_req(KIND_REFRESH);
        // parity latency added only with the loop off.
        check(took2 >= (rfc_n + 40) * 160, 1'b1);
        check(took < (rfc_n + 40) * 160, 1'b1);
        $display("Test refresh done.");
        do_reset();
        check(mem_cke, 1'b0);
        $display("Test mid-run reset done.");
        stop_test();
    end
endmodule : testbench
